// File: logic/bshc_debounce.sv
// ejector handle debouncer: level must hold steady for a full interval
`timescale 1ns/100ps
`default_nettype none
module bshc_debounce
  import bshc_pkg::*;
#(
  parameter int DEBOUNCE_CYC = BSHC_DEBOUNCE_CYC
)
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // raw synchronised level and filtered result
  input  wire logic level_in,
  output logic      level_out,
  output logic      rise,
  output logic      fall
);
  localparam int CW = $clog2(DEBOUNCE_CYC + 1);
  localparam logic [CW-1:0] CNT_LAST = CW'(DEBOUNCE_CYC - 1);

  logic [CW-1:0] count_reg;
  logic [CW-1:0] count_next;
  logic          level_reg;
  wire           differs = level_in != level_reg;
  wire           settled = differs && (count_reg == CNT_LAST);

  // restart on any bounce back to the held level
  assign count_next = !differs ? '0 : (settled ? '0 : count_reg + CW'(1));
  assign level_out  = level_reg;
  assign rise       = settled && level_in;
  assign fall       = settled && !level_in;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      count_reg <= '0;
      level_reg <= 1'b1;
    end
    else
    begin
      count_reg <= count_next;
      if (settled)
        level_reg <= level_in;
    end
  end
endmodule // bshc_debounce
`default_nettype wire

// File: logic/bshc_pkg.sv
// package: register map, fields, reset values and timing for the strap and hot-swap block
package bshc_pkg;
  // register byte offsets
  localparam logic [7:0] BSHC_OFS_CTRL    = 8'h00;
  localparam logic [7:0] BSHC_OFS_STATUS  = 8'h04;
  localparam logic [7:0] BSHC_OFS_GPIO_OE = 8'h08;
  localparam logic [7:0] BSHC_OFS_GPIO_DO = 8'h0C;
  localparam logic [7:0] BSHC_OFS_GPIO_DI = 8'h10;
  localparam logic [7:0] BSHC_OFS_EVT     = 8'h14;
  localparam logic [7:0] BSHC_OFS_MASK    = 8'h18;
  localparam logic [7:0] BSHC_OFS_CLKDIS  = 8'h1C;
  // control register fields
  localparam int BSHC_CTRL_LAMP  = 0;
  localparam int BSHC_CTRL_D3HOT = 1;
  // status register fields
  localparam int BSHC_ST_P66     = 0;
  localparam int BSHC_ST_S66     = 1;
  localparam int BSHC_ST_HALF    = 2;
  localparam int BSHC_ST_SWAPEN  = 3;
  localparam int BSHC_ST_B2      = 4;
  localparam int BSHC_ST_HANDLE  = 5;
  // event register fields
  localparam int BSHC_EV_INSERT  = 0;
  localparam int BSHC_EV_EXTRACT = 1;
  localparam int BSHC_EV_W       = 2;
  // reset values
  localparam logic [31:0] BSHC_CTRL_RST   = 32'h0000_0000;
  localparam logic [3:0]  BSHC_GPIO_RST   = 4'h0;
  localparam logic [1:0]  BSHC_MASK_RST   = 2'h0;
  localparam logic [31:0] BSHC_CLKDIS_RST = 32'h0000_0000;
  // timing
  localparam int BSHC_CLK_MHZ       = 100;
  localparam int BSHC_DEBOUNCE_US   = 1000;
  localparam int BSHC_DEBOUNCE_CYC  = BSHC_DEBOUNCE_US * BSHC_CLK_MHZ;
  // bus answers
  localparam logic [1:0] BSHC_RESP_OKAY   = 2'h0;
  localparam logic [1:0] BSHC_RESP_SLVERR = 2'h2;
endpackage : bshc_pkg

// File: logic/bshc_top.sv
// strap decode, secondary clock gating, gpio, hot-swap signalling and register slave
//
// Overview of operation
// (R1) primary speed input high selects 66 MHz, low selects 33 MHz.
// (R2) secondary speed line is wired-OR; 66 MHz only while it stays high.
// (R3) primary speed low: drive secondary speed line low during reset.
// (R4) clock strap high and D3hot: stop secondary clocks, hold them at 0.
// (R5) clock strap low: D3hot leaves secondary clocks running.
// (R6) four gpio pins, each set by output-enable and output-data, read back.
// (R7) hot-swap mode: gpio 3 is active-low ejector handle switch input.
// (R8) insertion or extraction on the switch drives the enumeration output low.
// (R9) status lamp follows software lamp bit: 0 off, 1 on.
// (R10) mode lo low, mode hi high: hot-swap enabled, pin 3 is switch.
// (R11) mode lo high: hot-swap disabled, pin 3 ordinary gpio.
// (R12) primary fast, secondary line low: secondary clocks at half rate; the code toggles them every CLK cycle at both speeds.
// (R13) straps synchronised; ejector switch debounced before an event.
//
// The address map and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module bshc_top
  import bshc_pkg::*;
#(
  parameter int NCLK         = 10,
  parameter int NGPIO        = 4,
  parameter int DEBOUNCE_CYC = BSHC_DEBOUNCE_CYC
)
(
  // clock and reset
  input  wire logic            CLK,
  input  wire logic            RST,
  // straps
  input  wire logic            PRIMARY_SPEED_SEL,
  input  wire logic            CLOCK_POWER_STRAP,
  input  wire logic            MODE_SELECT_LO,
  input  wire logic            MODE_SELECT_HI,
  // secondary speed open-drain line
  input  wire logic            SECONDARY_SPEED_LINE_I,
  output logic                 SECONDARY_SPEED_LINE_O,
  output logic                 SECONDARY_SPEED_LINE_OE,
  // secondary clock outputs and speed status
  output logic [NCLK-1:0]      SEC_CLK_OUT,
  output logic                 PRIMARY_FAST,
  // gpio pins
  input  wire logic [NGPIO-1:0] GPIO_I,
  output logic [NGPIO-1:0]     GPIO_O,
  output logic [NGPIO-1:0]     GPIO_OE,
  // hot-swap outputs and interrupt
  output logic                 INSERT_EVENT_N,
  output logic                 SWAP_STATUS_LAMP,
  output logic                 IRQ,
  // axi4-lite write address
  input  wire logic [7:0]      S_AXI_AWADDR,
  input  wire logic            S_AXI_AWVALID,
  output logic                 S_AXI_AWREADY,
  // axi4-lite write data
  input  wire logic [31:0]     S_AXI_WDATA,
  input  wire logic [3:0]      S_AXI_WSTRB,
  input  wire logic            S_AXI_WVALID,
  output logic                 S_AXI_WREADY,
  // axi4-lite write response
  output logic [1:0]           S_AXI_BRESP,
  output logic                 S_AXI_BVALID,
  input  wire logic            S_AXI_BREADY,
  // axi4-lite read address
  input  wire logic [7:0]      S_AXI_ARADDR,
  input  wire logic            S_AXI_ARVALID,
  output logic                 S_AXI_ARREADY,
  // axi4-lite read data
  output logic [31:0]          S_AXI_RDATA,
  output logic [1:0]           S_AXI_RRESP,
  output logic                 S_AXI_RVALID,
  input  wire logic            S_AXI_RREADY
);
  // two-flop synchronisers for straps, speed line and gpio inputs
  localparam int NSYNC = 5 + NGPIO;
  logic [NSYNC-1:0] sync1_reg;
  logic [NSYNC-1:0] sync2_reg;
  wire  [NSYNC-1:0] raw_in = {GPIO_I, SECONDARY_SPEED_LINE_I, MODE_SELECT_HI,
                              MODE_SELECT_LO, CLOCK_POWER_STRAP, PRIMARY_SPEED_SEL};
  wire              p66_s   = sync2_reg[0];
  wire              cps_s   = sync2_reg[1];
  wire              ms_lo_s = sync2_reg[2];
  wire              ms_hi_s = sync2_reg[3];
  wire              s66_s   = sync2_reg[4];
  wire [NGPIO-1:0]  gpio_s  = sync2_reg[NSYNC-1:5];

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end
    else
    begin
      sync1_reg <= raw_in; // R13
      sync2_reg <= sync1_reg;
    end
  end

  // software registers
  logic [31:0]      ctrl_reg;
  logic [NGPIO-1:0] gpio_oe_reg;
  logic [NGPIO-1:0] gpio_do_reg;
  logic [BSHC_EV_W-1:0] evt_reg;
  logic [BSHC_EV_W-1:0] mask_reg;
  logic [NCLK-1:0]  clkdis_reg;

  // mode and speed decode
  wire swap_en   = !ms_lo_s && ms_hi_s;  // R10
  wire half_rate = p66_s && !s66_s;      // R12
  wire b2_state  = cps_s && ctrl_reg[BSHC_CTRL_D3HOT]; // R4 R5
  assign PRIMARY_FAST = p66_s;            // R1

  // open-drain pull-down held only while reset is asserted
  assign SECONDARY_SPEED_LINE_O  = 1'b0;
  assign SECONDARY_SPEED_LINE_OE = RST && !PRIMARY_SPEED_SEL; // R3 R2

  // secondary clocks: a register tops out at half rate, so both speeds share one toggle
  logic div_reg;
  logic [NCLK-1:0] sclk_reg;
  wire  [NCLK-1:0] clk_run = ~clkdis_reg & {NCLK{!b2_state}}; // R4
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      div_reg  <= 1'b0;
      sclk_reg <= '0;
    end
    else
    begin
      div_reg  <= !div_reg;
      sclk_reg <= clk_run & {NCLK{!div_reg}}; // R12
    end
  end
  assign SEC_CLK_OUT = sclk_reg;

  // gpio pins; pin 3 becomes the switch input in hot-swap mode
  wire [NGPIO-1:0] pin_own = {swap_en, {(NGPIO-1){1'b0}}}; // R7 R11
  assign GPIO_O  = gpio_do_reg;
  assign GPIO_OE = gpio_oe_reg & ~pin_own; // R6

  // ejector switch debounce and events
  logic handle_level;
  logic handle_rise;
  logic handle_fall;
  bshc_debounce #(
    .DEBOUNCE_CYC (DEBOUNCE_CYC)
  ) u_debounce (
    .clk       (CLK),
    .rst       (RST),
    .level_in  (gpio_s[NGPIO-1]),
    .level_out (handle_level),
    .rise      (handle_rise),
    .fall      (handle_fall)
  );
  // switch closing (low) marks insertion, opening marks extraction
  wire [BSHC_EV_W-1:0] evt_set = {handle_rise, handle_fall} & {BSHC_EV_W{swap_en}}; // R13

  assign INSERT_EVENT_N   = !(|evt_reg); // R8
  assign SWAP_STATUS_LAMP = ctrl_reg[BSHC_CTRL_LAMP]; // R9
  assign IRQ              = |(evt_reg & mask_reg);

  // axi4-lite slave: one write and one read at a time
  logic aw_hold_reg;
  logic w_hold_reg;
  logic [7:0]  awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        rvalid_reg;
  logic [1:0]  rresp_reg;
  logic [31:0] rdata_reg;

  assign S_AXI_AWREADY = !aw_hold_reg && !bvalid_reg;
  assign S_AXI_WREADY  = !w_hold_reg && !bvalid_reg;
  assign S_AXI_ARREADY = !rvalid_reg;
  assign S_AXI_BVALID  = bvalid_reg;
  assign S_AXI_BRESP   = bresp_reg;
  assign S_AXI_RVALID  = rvalid_reg;
  assign S_AXI_RRESP   = rresp_reg;
  assign S_AXI_RDATA   = rdata_reg;

  wire aw_take = S_AXI_AWVALID && S_AXI_AWREADY;
  wire w_take  = S_AXI_WVALID && S_AXI_WREADY;
  wire ar_take = S_AXI_ARVALID && S_AXI_ARREADY;
  wire have_aw = aw_hold_reg || aw_take;
  wire have_w  = w_hold_reg || w_take;
  wire do_wr   = have_aw && have_w;
  wire [7:0]  wr_addr = aw_hold_reg ? awaddr_reg : S_AXI_AWADDR;
  wire [31:0] wr_data = w_hold_reg ? wdata_reg : S_AXI_WDATA;
  wire [3:0]  wr_strb = w_hold_reg ? wstrb_reg : S_AXI_WSTRB;

  function automatic logic known(input logic [7:0] a);
    known = (a == BSHC_OFS_CTRL) || (a == BSHC_OFS_STATUS) || (a == BSHC_OFS_GPIO_OE)
         || (a == BSHC_OFS_GPIO_DO) || (a == BSHC_OFS_GPIO_DI) || (a == BSHC_OFS_EVT)
         || (a == BSHC_OFS_MASK) || (a == BSHC_OFS_CLKDIS);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    for (int i = 0; i < 4; i++)
      merge[8*i +: 8] = strb[i] ? nw[8*i +: 8] : old[8*i +: 8];
  endfunction

  wire [31:0] wr_word = merge(32'h0000_0000, wr_data, wr_strb);
  wire wr_ctrl = do_wr && wr_addr == BSHC_OFS_CTRL;
  wire wr_oe   = do_wr && wr_addr == BSHC_OFS_GPIO_OE;
  wire wr_do   = do_wr && wr_addr == BSHC_OFS_GPIO_DO;
  wire wr_evt  = do_wr && wr_addr == BSHC_OFS_EVT;
  wire wr_mask = do_wr && wr_addr == BSHC_OFS_MASK;
  wire wr_cdis = do_wr && wr_addr == BSHC_OFS_CLKDIS;

  wire [31:0] status_word = 32'({handle_level, b2_state, swap_en, half_rate, s66_s, p66_s});
  wire [31:0] rd_word =
      (S_AXI_ARADDR == BSHC_OFS_CTRL)    ? ctrl_reg :
      (S_AXI_ARADDR == BSHC_OFS_STATUS)  ? status_word :
      (S_AXI_ARADDR == BSHC_OFS_GPIO_OE) ? 32'(gpio_oe_reg) :
      (S_AXI_ARADDR == BSHC_OFS_GPIO_DO) ? 32'(gpio_do_reg) :
      (S_AXI_ARADDR == BSHC_OFS_GPIO_DI) ? 32'(gpio_s) :
      (S_AXI_ARADDR == BSHC_OFS_EVT)     ? 32'(evt_reg) :
      (S_AXI_ARADDR == BSHC_OFS_MASK)    ? 32'(mask_reg) :
      (S_AXI_ARADDR == BSHC_OFS_CLKDIS)  ? 32'(clkdis_reg) : 32'h0000_0000;

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      aw_hold_reg <= 1'b0;
      w_hold_reg  <= 1'b0;
      awaddr_reg  <= 8'h00;
      wdata_reg   <= 32'h0000_0000;
      wstrb_reg   <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= BSHC_RESP_OKAY;
      rvalid_reg  <= 1'b0;
      rresp_reg   <= BSHC_RESP_OKAY;
      rdata_reg   <= 32'h0000_0000;
    end
    else
    begin
      if (aw_take)
        awaddr_reg <= S_AXI_AWADDR;
      if (w_take)
      begin
        wdata_reg <= S_AXI_WDATA;
        wstrb_reg <= S_AXI_WSTRB;
      end
      aw_hold_reg <= have_aw && !do_wr;
      w_hold_reg  <= have_w && !do_wr;
      if (do_wr)
      begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= known(wr_addr) ? BSHC_RESP_OKAY : BSHC_RESP_SLVERR;
      end
      else if (S_AXI_BREADY)
        bvalid_reg <= 1'b0;
      if (ar_take)
      begin
        rvalid_reg <= 1'b1;
        rdata_reg  <= rd_word;
        rresp_reg  <= known(S_AXI_ARADDR) ? BSHC_RESP_OKAY : BSHC_RESP_SLVERR;
      end
      else if (S_AXI_RREADY)
        rvalid_reg <= 1'b0;
    end
  end

  // register file; event set wins over a write-one clear
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      ctrl_reg    <= BSHC_CTRL_RST;
      gpio_oe_reg <= BSHC_GPIO_RST;
      gpio_do_reg <= BSHC_GPIO_RST;
      evt_reg     <= '0;
      mask_reg    <= BSHC_MASK_RST;
      clkdis_reg  <= NCLK'(BSHC_CLKDIS_RST);
    end
    else
    begin
      if (wr_ctrl)
        ctrl_reg <= merge(ctrl_reg, wr_data, wr_strb) & 32'h0000_0003; // R9
      if (wr_oe)
        gpio_oe_reg <= wr_word[NGPIO-1:0]; // R6
      if (wr_do)
        gpio_do_reg <= wr_word[NGPIO-1:0]; // R6
      if (wr_mask)
        mask_reg <= wr_word[BSHC_EV_W-1:0];
      if (wr_cdis)
        clkdis_reg <= wr_word[NCLK-1:0];
      evt_reg <= (evt_reg & ~(wr_evt ? wr_word[BSHC_EV_W-1:0] : '0)) | evt_set; // R8
    end
  end
endmodule // bshc_top
`default_nettype wire

// File: tb/bshc_checker.sv
// checker: port-level timing relations of the strap and hot-swap block
`timescale 1ns/100ps
`default_nettype none
module bshc_checker
  import bshc_pkg::*;
#(
  parameter int NCLK  = 10,
  parameter int NGPIO = 4
)
(
  // clock and reset
  input wire logic             CLK,
  input wire logic             RST,
  // straps and speed line
  input wire logic             PRIMARY_SPEED_SEL,
  input wire logic             CLOCK_POWER_STRAP,
  input wire logic             PRIMARY_FAST,
  input wire logic             MODE_SELECT_LO,
  input wire logic             MODE_SELECT_HI,
  input wire logic             SECONDARY_SPEED_LINE_O,
  input wire logic             SECONDARY_SPEED_LINE_OE,
  // clocks, pins and hot-swap
  input wire logic [NCLK-1:0]  SEC_CLK_OUT,
  input wire logic [NGPIO-1:0] GPIO_I,
  input wire logic [NGPIO-1:0] GPIO_OE,
  input wire logic             INSERT_EVENT_N,
  input wire logic             IRQ,
  // bus handshakes
  input wire logic             S_AXI_AWVALID,
  input wire logic             S_AXI_AWREADY,
  input wire logic             S_AXI_WVALID,
  input wire logic             S_AXI_WREADY,
  input wire logic             S_AXI_BVALID,
  input wire logic             S_AXI_ARVALID,
  input wire logic             S_AXI_ARREADY,
  input wire logic             S_AXI_RVALID
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  sequence wr_taken;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  endsequence
  // the pull acts inside reset, so reset must not mask it
  speed_pull_a: assert property (disable iff (1'h0)
    RST && !PRIMARY_SPEED_SEL |-> SECONDARY_SPEED_LINE_OE && !SECONDARY_SPEED_LINE_O)
    else $error("speed line not pulled low in reset");
  fast_sync_a: assert property ($stable(PRIMARY_SPEED_SEL)[*7] |->
    PRIMARY_FAST == PRIMARY_SPEED_SEL) else $error("primary speed status stale");
  swap_pin_a: assert property ((!MODE_SELECT_LO && MODE_SELECT_HI)[*7] |->
    !GPIO_OE[3]) else $error("pin 3 driven in hot-swap mode");
  no_swap_a: assert property (MODE_SELECT_LO[*7] ##0 INSERT_EVENT_N |=>
    INSERT_EVENT_N) else $error("event raised with hot-swap off");
  evt_irq_a: assert property (INSERT_EVENT_N |-> !IRQ)
    else $error("interrupt without pending event");
  // a bare synchroniser would fall three edges after the pin moved
  debounce_a: assert property ($fell(INSERT_EVENT_N) |->
    $past(GPIO_I[3], 2) == $past(GPIO_I[3], 4)) else $error("event from unsettled switch");
  wr_resp_a: assert property (wr_taken |=> S_AXI_BVALID)
    else $error("write response late");
  rd_resp_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read data late");
  clk_run_a: assert property ((!CLOCK_POWER_STRAP)[*7] |->
    SEC_CLK_OUT != $past(SEC_CLK_OUT)) else $error("secondary clocks stopped");
endmodule // bshc_checker
bind bshc_top bshc_checker #(.NCLK(NCLK), .NGPIO(NGPIO)) chk_i (.*);
`default_nettype wire

// File: tb/bshc_partner.sv
// partner: secondary speed line and board side of the gpio pins
`timescale 1ns/100ps
`default_nettype none
module bshc_partner
(
  // levels set by the bench
  input wire logic       slow_dev,
  input wire logic [3:0] ext,
  // block side
  input wire logic       speed_o,
  input wire logic       speed_oe,
  input wire logic [3:0] gpio_o,
  input wire logic [3:0] gpio_oe,
  output logic           speed_line,
  output logic [3:0]     pins
);
  // pulled up; a slow device or the bridge sinks it
  assign speed_line = !(speed_oe && !speed_o) && !slow_dev;
  // undriven pins show the board level, pin 3 the handle switch
  assign pins = (gpio_oe & gpio_o) | (~gpio_oe & ext);
endmodule // bshc_partner
`default_nettype wire

// File: tb/bshc_top_tb.sv
// testbench: register rows, speed, clock gating and hot-swap tests
`timescale 1ns/100ps
`default_nettype none
module bshc_top_tb;
  import bshc_pkg::*;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e; logic [1:0] r;} bshc_row_type;
  logic        CLK = 1'h0, RST = 1'h1, PRIMARY_SPEED_SEL = 1'h0, CLOCK_POWER_STRAP = 1'h0;
  logic        MODE_SELECT_LO = 1'h1, MODE_SELECT_HI = 1'h0, slow_dev = 1'h1;
  logic        SECONDARY_SPEED_LINE_I, SECONDARY_SPEED_LINE_O, SECONDARY_SPEED_LINE_OE;
  logic        PRIMARY_FAST, INSERT_EVENT_N, SWAP_STATUS_LAMP, IRQ;
  logic [9:0]  SEC_CLK_OUT, v;
  logic [3:0]  GPIO_I, GPIO_O, GPIO_OE, ext = 4'hA, S_AXI_WSTRB = 4'hF;
  logic [7:0]  S_AXI_AWADDR = 8'h0, S_AXI_ARADDR = 8'h0;
  logic [31:0] S_AXI_WDATA = 32'h0, S_AXI_RDATA, rdv;
  logic [1:0]  S_AXI_BRESP, S_AXI_RRESP, rsp;
  logic        S_AXI_AWVALID = 1'h0, S_AXI_WVALID = 1'h0, S_AXI_BREADY = 1'h0;
  logic        S_AXI_ARVALID = 1'h0, S_AXI_RREADY = 1'h0;
  logic        S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
  int          fails = 0, check_count = 0, cyc = 0;
  // event register first: a write of zero must leave its reset value
  bshc_row_type rows [6] = '{
    '{BSHC_OFS_EVT, 32'h0, 32'h0, BSHC_RESP_OKAY},
    '{BSHC_OFS_CTRL, 32'h1, 32'h1, BSHC_RESP_OKAY},
    '{BSHC_OFS_GPIO_OE, 32'h5, 32'h5, BSHC_RESP_OKAY},
    '{BSHC_OFS_GPIO_DO, 32'h1, 32'h1, BSHC_RESP_OKAY},
    '{BSHC_OFS_MASK, 32'h1, 32'h1, BSHC_RESP_OKAY},
    '{8'h40, 32'hFFFF_FFFF, 32'h0, BSHC_RESP_SLVERR}};

  bshc_top #(.DEBOUNCE_CYC(4)) DUT (.*);
  bshc_partner far_side (.slow_dev(slow_dev), .ext(ext), .speed_o(SECONDARY_SPEED_LINE_O),
    .speed_oe(SECONDARY_SPEED_LINE_OE), .gpio_o(GPIO_O), .gpio_oe(GPIO_OE),
    .speed_line(SECONDARY_SPEED_LINE_I), .pins(GPIO_I));

  always #5 CLK = ~CLK;

  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  always @(posedge CLK)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      fails++;
      test_done();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // one write or one read; ready looked at mid-cycle since inputs move only on edges
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tr, tv;
    @(posedge CLK);
    S_AXI_AWADDR <= a;
    S_AXI_ARADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= w;
    S_AXI_WVALID <= w;
    S_AXI_BREADY <= w;
    S_AXI_ARVALID <= !w;
    S_AXI_RREADY <= !w;
    repeat (100)
    begin
      @(negedge CLK);
      ta = S_AXI_AWREADY;
      tw = S_AXI_WREADY;
      tr = S_AXI_ARREADY;
      tv = S_AXI_BVALID || S_AXI_RVALID;
      rdv = S_AXI_RDATA;
      rsp = S_AXI_BVALID ? S_AXI_BRESP : S_AXI_RRESP;
      @(posedge CLK);
      if (ta) S_AXI_AWVALID <= 1'h0;
      if (tw) S_AXI_WVALID <= 1'h0;
      if (tr) S_AXI_ARVALID <= 1'h0;
      if (tv) break;
    end
    chk({31'h0, tv}, 32'h1);
    S_AXI_BREADY <= 1'h0;
    S_AXI_RREADY <= 1'h0;
  endtask

  initial
  begin
    repeat (9) @(posedge CLK);
    @(negedge CLK);
    chk({INSERT_EVENT_N, IRQ, SECONDARY_SPEED_LINE_OE, SWAP_STATUS_LAMP}, 32'hA);
    @(posedge CLK);
    RST <= 1'h0;
    $display("reset test done");
    foreach (rows[i])
    begin
      bus(1'h1, rows[i].a, rows[i].d);
      chk(rsp, rows[i].r);
      bus(1'h0, rows[i].a, 32'h0);
      chk(rdv, rows[i].e);
      chk(rsp, rows[i].r);
    end
    @(negedge CLK);
    chk({SWAP_STATUS_LAMP, GPIO_OE, GPIO_O}, 32'h151);
    bus(1'h0, BSHC_OFS_GPIO_DI, 32'h0);
    chk(rdv, 32'hB);
    $display("register rows done");
    PRIMARY_SPEED_SEL <= 1'h1;
    repeat (8) @(posedge CLK);
    bus(1'h0, BSHC_OFS_STATUS, 32'h0);
    chk(rdv, 32'h25);
    chk({31'h0, PRIMARY_FAST}, 32'h1);
    slow_dev <= 1'h0;
    repeat (8) @(posedge CLK);
    bus(1'h0, BSHC_OFS_STATUS, 32'h0);
    chk(rdv, 32'h23);
    CLOCK_POWER_STRAP <= 1'h1;
    bus(1'h1, BSHC_OFS_CTRL, 32'h3);
    repeat (6) @(negedge CLK);
    chk(SEC_CLK_OUT, 32'h0);
    bus(1'h0, BSHC_OFS_STATUS, 32'h0);
    chk(rdv, 32'h33);
    CLOCK_POWER_STRAP <= 1'h0;
    repeat (8) @(negedge CLK);
    v = SEC_CLK_OUT;
    @(negedge CLK);
    chk(SEC_CLK_OUT ^ v, 32'h3FF);
    $display("speed and clock tests done");
    @(posedge CLK);
    MODE_SELECT_LO <= 1'h0;
    MODE_SELECT_HI <= 1'h1;
    repeat (6) @(posedge CLK);
    bus(1'h1, BSHC_OFS_GPIO_OE, 32'hD);
    @(negedge CLK);
    chk(GPIO_OE, 32'h5);
    @(posedge CLK);
    ext[3] <= 1'h0;
    repeat (2) @(posedge CLK);
    ext[3] <= 1'h1;
    repeat (12) @(negedge CLK);
    chk(INSERT_EVENT_N, 32'h1);
    @(posedge CLK);
    ext[3] <= 1'h0;
    repeat (12) @(negedge CLK);
    chk({INSERT_EVENT_N, IRQ}, 32'h1);
    bus(1'h0, BSHC_OFS_EVT, 32'h0);
    chk(rdv, 32'h1);
    bus(1'h1, BSHC_OFS_EVT, 32'h1);
    @(negedge CLK);
    chk({INSERT_EVENT_N, IRQ}, 32'h2);
    @(posedge CLK);
    ext[3] <= 1'h1;
    repeat (12) @(negedge CLK);
    chk({INSERT_EVENT_N, IRQ}, 32'h0);
    bus(1'h0, BSHC_OFS_EVT, 32'h0);
    chk(rdv, 32'h2);
    bus(1'h1, BSHC_OFS_EVT, 32'h2);
    // no strobed byte: control keeps its lamp and power bits
    S_AXI_WSTRB <= 4'h0;
    bus(1'h1, BSHC_OFS_CTRL, 32'h0);
    S_AXI_WSTRB <= 4'hF;
    bus(1'h0, BSHC_OFS_CTRL, 32'h0);
    chk(rdv, 32'h3);
    $display("hot-swap tests done");
    MODE_SELECT_LO <= 1'h1;
    repeat (6) @(posedge CLK);
    bus(1'h1, BSHC_OFS_GPIO_OE, 32'hD);
    repeat (12) @(negedge CLK);
    chk({INSERT_EVENT_N, GPIO_OE}, 32'h1D);
    $display("ordinary pin test done");
    @(posedge CLK);
    RST <= 1'h1;
    repeat (2) @(posedge CLK);
    @(negedge CLK);
    chk({SWAP_STATUS_LAMP, GPIO_OE, SECONDARY_SPEED_LINE_OE}, 32'h0);
    @(posedge CLK);
    RST <= 1'h0;
    bus(1'h0, BSHC_OFS_CTRL, 32'h0);
    chk(rdv, 32'h0);
    $display("second reset test done");
    test_done();
  end
endmodule // bshc_top_tb
`default_nettype wire
